// File: src/ssa_pkg.sv
// Constants and types for the serial signed add order block
package ssa_pkg;

	// ------------------------------------------------------------
	// Word and pulse timing (one bit per pclk, 42 pulses per minor cycle)
	// ------------------------------------------------------------
	localparam int         WORD_W      = 42;
	localparam int         HI_W        = WORD_W - 32;
	localparam logic [5:0] T_LAST      = 6'd41;
	localparam logic [5:0] T_CMP_RST   = 6'd1;
	localparam logic [5:0] T_FLAG_RST  = 6'd2;
	localparam logic [5:0] T_SLOT_STEP = 6'd2;
	localparam logic [5:0] T_CP_FIRST  = 6'd6;
	localparam logic [5:0] T_MAG       = 6'd34;
	localparam logic [5:0] T_SIGN      = 6'd35;
	localparam logic [5:0] T_CP_LAST   = 6'd35;
	localparam logic [5:0] T_P0        = 6'd40;
	localparam logic [5:0] MSB_BIT     = 6'd36;
	localparam logic [5:0] SIGN_BIT    = 6'd37;
	localparam logic [3:0] SLOT_LAST   = 4'h9;

	// ------------------------------------------------------------
	// Stages, steps and control lines
	// ------------------------------------------------------------
	typedef enum logic [1:0] {STG_ALPHA, STG_BETA, STG_GAMMA, STG_DELTA} ssa_stage_e;
	typedef enum logic [1:0] {STEP_FETCH, STEP_COMPARE, STEP_ADD, STEP_SPARE} ssa_step_e;
	localparam logic [20:0] FL_FETCH   = 21'h08100a;  // Lines 1, 3, 12, 19
	localparam logic [20:0] FL_COMPARE = 21'h012000;  // Lines 13, 16
	localparam logic [20:0] FL_ADD     = 21'h104400;  // Lines 10, 14, 20

	// ------------------------------------------------------------
	// Register map, field positions, reset values
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_ACC_LO   = 12'h008;
	localparam logic [11:0] REG_ACC_HI   = 12'h00c;
	localparam logic [11:0] REG_OPND_LO  = 12'h010;
	localparam logic [11:0] REG_OPND_HI  = 12'h014;
	localparam logic [11:0] REG_MEM_BASE = 12'h040;
	localparam logic [11:0] REG_MEM_END  = 12'h090;
	localparam logic [4:0]  MEM_IDX_OFS  = 5'h08;
	localparam int CTRL_GO      = 0;
	localparam int CTRL_OVF_CLR = 1;
	localparam int CTRL_ADDR    = 4;
	localparam int ST_STAGE     = 0;
	localparam int ST_STEP      = 2;
	localparam int ST_HOLD      = 4;
	localparam int ST_MAG       = 5;
	localparam int ST_SDIFF     = 6;
	localparam int ST_OVF       = 7;
	localparam int ST_CP        = 8;
	localparam int ST_S2        = 9;
	localparam int ST_BUSY      = 10;
	localparam int ST_SLOT      = 12;
	localparam int ST_ADDR      = 16;
	localparam logic [3:0] RST_ADDR = 4'h0;

endpackage : ssa_pkg

// File: src/ssa_add_if.sv
// Interface between the add sequencer and the serial binary adder
`timescale 1ns/1ps
`default_nettype none
interface ssa_add_if;
	logic upper;   // Upper adder input bit
	logic lower;   // Lower adder input bit, after complementer and sign strip
	logic inject;  // Initial carry pulse for subtraction
	logic clear;   // Holds the carry delay empty outside the add step
	logic kill;    // Stops this carry from reaching the next column
	logic sum;
	logic carry;
	modport core  (output upper, output lower, output inject, output clear, output kill, input sum, input carry);
	modport adder (input upper, input lower, input inject, input clear, input kill, output sum, output carry);
endinterface : ssa_add_if
`default_nettype wire

// File: src/ssa_serial_adder.sv
// Serial binary adder with one-bit carry delay
`timescale 1ns/1ps
`default_nettype none
module ssa_serial_adder
	import ssa_pkg::*;
(
	input wire logic  pclk,
	input wire logic  presetn,
	ssa_add_if.adder  ad
);

	typedef struct packed {
		logic carry;
	} ssa_adder_s;

	ssa_adder_s q;
	ssa_adder_s d;
	logic       cin;

	// ------------------------------------------------------------
	// Full adder on the current column
	// ------------------------------------------------------------
	// Delayed carry plus the injected pulse form the third input
	assign cin      = q.carry | ad.inject;
	assign ad.sum   = ad.upper ^ ad.lower ^ cin;
	assign ad.carry = (ad.upper & ad.lower) | (cin & (ad.upper ^ ad.lower));

	// Carry is delayed one bit time before it is fed back
	always_comb begin
		d = q;
		d.carry = ~ad.clear & ~ad.kill & ad.carry;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : ssa_serial_adder
`default_nettype wire

// File: src/ssa_top.sv
// Serial signed add order: three-step sequencer, comparator and adder path
// ------------------------------------------------------------
// How it works
// - Fetch, compare, add run as steps
// - Sign differ flag set when signs differ
// - Slot matching selected word means word emerges next t0
// - Magnitude flag set at t34 if greater
// - Adder never yields a negative zero
// - After compare, next t0 advances step
// - Hold interval protects both comparison flags
// - Add step raises lines 10, 14, 20
// - Sign differ selects complement, i.e. subtraction
// - Operand upper select swaps adder inputs
// - Pulses 6..35 complement the lower input
// - Lower input sign pulse is stripped
// - Sum replaces accumulator bits in step
// - Carry delayed one bit, fed back
// - Subtraction injects initial carry pulse
// - True addition carry from p36 overflows
// - Overflow keeps hold interval set until software clears it
// - Expected carry in subtraction never overflows
// - Line 10 ending pulse returns stage 00
// ------------------------------------------------------------
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssa_top
	import ssa_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        hold_interval,
	output var  logic [1:0]  stage_counter,
	output var  logic [1:0]  step_counter,
	output var  logic        overflow_flag,
	output var  logic [20:0] control_line
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [9:0][WORD_W-1:0] mem;     // Ten-word channel
		logic [WORD_W-1:0]      acc;     // Accumulator register
		logic [WORD_W-1:0]      opnd;    // Operand register
		logic [5:0]             pulse;   // Pulse generator t0..t41
		logic [3:0]             slot;    // Word slot counter
		logic [3:0]             addr;    // Selected word
		ssa_stage_e             stage;
		ssa_step_e              step;
		logic                   start;
		logic                   hold;
		logic                   tsel;    // Time selection minor cycle
		logic                   cmp_gt;  // Running serial magnitude compare
		logic                   mag;     // Magnitude greater flag
		logic                   sdiff;   // Sign differ flag
		logic                   ovf;
		logic                   nonzero; // Sum magnitude has a one
		logic [20:0]            fline;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
	} ssa_state_s;

	ssa_state_s q;
	ssa_state_s d;
	ssa_add_if  ad ();

	logic [5:0] bit_idx;
	logic       run;
	logic       fetching;
	logic       comparing;
	logic       adding;
	logic       complement_enable;
	logic       operand_upper_select;
	logic       acc_bit;
	logic       opnd_bit;
	logic       lower_raw;
	logic       cp_win;
	logic       cmp_now;
	logic       sum_bit;
	logic       busy;
	logic       setup;
	logic       wr;
	logic [4:0] mem_idx;
	logic       mem_hit;

	// ------------------------------------------------------------
	// Datapath steering
	// ------------------------------------------------------------
	// Bit p0 passes at t40, so the column index lags the pulse by 40
	assign bit_idx   = (q.pulse >= T_P0) ? q.pulse - T_P0 : q.pulse + 6'(WORD_W - 40);
	assign run       = (q.stage == STG_GAMMA) && !q.hold;
	assign fetching  = run && (q.step == STEP_FETCH) && q.tsel;
	assign comparing = run && (q.step == STEP_COMPARE);
	assign adding    = run && (q.step == STEP_ADD);
	assign acc_bit   = q.acc[bit_idx];
	assign opnd_bit  = q.opnd[bit_idx];
	assign cmp_now   = (acc_bit != opnd_bit) ? acc_bit : q.cmp_gt;

	// Subtract when signs differ; smaller magnitude goes to the complementer
	assign complement_enable    = (q.stage == STG_GAMMA) && (q.step == STEP_ADD) && q.sdiff;
	assign operand_upper_select = !q.mag;
	assign cp_win    = complement_enable && (q.pulse >= T_CP_FIRST) && (q.pulse <= T_CP_LAST);
	assign lower_raw = operand_upper_select ? acc_bit : opnd_bit;

	// Adder inputs; the lower sign pulse is stripped after the complementer
	assign ad.upper  = operand_upper_select ? opnd_bit : acc_bit;
	assign ad.lower  = (bit_idx == SIGN_BIT) ? 1'b0 : (lower_raw ^ cp_win);
	assign ad.inject = complement_enable && (q.pulse == T_CP_FIRST);
	assign ad.clear  = !adding;
	assign ad.kill   = (q.pulse == T_MAG);  // Carry out of p36 never reaches the sign column

	// Result sign follows the upper input, forced plus when magnitude is zero
	assign sum_bit = (bit_idx == SIGN_BIT) ? (ad.upper & q.nonzero) : ad.sum;

	// Bus side decode helpers
	assign busy    = (q.stage != STG_ALPHA) || q.start;
	assign setup   = psel && !penable;
	assign wr      = psel && penable && q.pready && pwrite;
	assign mem_idx = paddr[7:3] - MEM_IDX_OFS;
	assign mem_hit = (paddr >= REG_MEM_BASE) && (paddr < REG_MEM_END);

	ssa_serial_adder ssa_serial_adder_i (
		.pclk    (pclk),
		.presetn (presetn),
		.ad      (ad.adder)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;

		// Pulse generator stepped every pclk, word slot counter stepped at t2
		d.pulse = (q.pulse == T_LAST) ? 6'd0 : q.pulse + 6'd1;
		if (q.pulse == T_SLOT_STEP) begin
			d.slot = (q.slot == SLOT_LAST) ? 4'h0 : q.slot + 4'h1;
		end

		// Fetch: selected word streams p1 first from t1, p0 last at the closing t0, into the operand register
		if (fetching) begin
			d.opnd[q.pulse] = q.mem[q.addr][q.pulse];
		end

		// Compare: flags only reset while no hold is present
		if (comparing) begin
			if (q.pulse == T_CMP_RST) begin
				d.cmp_gt = 1'b0;
			end else if (bit_idx <= MSB_BIT) begin
				d.cmp_gt = cmp_now;
			end
			if (q.pulse == T_FLAG_RST) begin
				d.mag   = 1'b0;
				d.sdiff = 1'b0;
			end
			if (q.pulse == T_MAG) begin
				d.mag = cmp_now;
			end
			if (q.pulse == T_SIGN) begin
				d.sdiff = q.acc[SIGN_BIT] ^ q.opnd[SIGN_BIT];
			end
		end

		// Add: sum written back into the same column, old bit dropped
		if (adding) begin
			d.acc[bit_idx] = sum_bit;
			if (q.pulse == T_CMP_RST) begin
				d.nonzero = ad.sum;
			end else if (bit_idx <= MSB_BIT) begin
				d.nonzero = q.nonzero | ad.sum;
			end
		end

		// Software overflow clear comes first so a same-cycle carry still sets
		if (wr && (paddr == REG_CTRL) && pwdata[CTRL_OVF_CLR]) begin
			d.ovf = 1'b0;
		end
		if (adding && (q.pulse == T_MAG) && ad.carry && !complement_enable) begin
			d.ovf = 1'b1;
		end

		// Sequencer: every transition happens on a t0 pulse
		if (q.pulse == 6'd0) begin
			if (q.start) begin
				d.start = 1'b0;
				d.stage = STG_GAMMA;
				d.step  = STEP_FETCH;
				d.hold  = 1'b1;
				d.tsel  = 1'b0;
			end else if (q.hold) begin
				if (!q.ovf) begin
					d.hold = 1'b0;
				end
			end else if (q.stage == STG_GAMMA) begin
				case (q.step)
					STEP_FETCH: begin
						if (q.tsel) begin
							d.tsel = 1'b0;
							d.step = STEP_COMPARE;
							d.hold = 1'b1;
						end else if (q.slot == q.addr) begin
							d.tsel = 1'b1;
						end
					end
					STEP_COMPARE: begin
						d.step = STEP_ADD;
						d.hold = 1'b1;
					end
					default: begin
						d.hold  = 1'b1;
						d.step  = STEP_FETCH;
						d.stage = STG_ALPHA;
					end
				endcase
			end
		end

		// Control lines follow the step counter while in the gamma stage
		if (d.stage != STG_GAMMA) begin
			d.fline = '0;
		end else if (d.step == STEP_FETCH) begin
			d.fline = FL_FETCH;
		end else if (d.step == STEP_COMPARE) begin
			d.fline = FL_COMPARE;
		end else begin
			d.fline = FL_ADD;
		end

		// APB writes take effect at the access edge; data path locked while busy
		if (wr) begin
			if (paddr == REG_CTRL) begin
				if (pwdata[CTRL_GO] && !busy) begin
					d.start = 1'b1;
					d.addr  = pwdata[CTRL_ADDR +: 4];
				end
			end else if (busy) begin
				d.pslverr = 1'b0;
			end else if (paddr == REG_ACC_LO) begin
				d.acc[31:0] = pwdata;
			end else if (paddr == REG_ACC_HI) begin
				d.acc[WORD_W-1:32] = pwdata[HI_W-1:0];
			end else if (paddr == REG_OPND_LO) begin
				d.opnd[31:0] = pwdata;
			end else if (paddr == REG_OPND_HI) begin
				d.opnd[WORD_W-1:32] = pwdata[HI_W-1:0];
			end else if (mem_hit && !paddr[2]) begin
				d.mem[mem_idx][31:0] = pwdata;
			end else if (mem_hit) begin
				d.mem[mem_idx][WORD_W-1:32] = pwdata[HI_W-1:0];
			end
		end

		// APB read data and answer prepared in the setup cycle
		d.pready  = setup;
		d.pslverr = 1'b0;
		d.prdata  = '0;
		if (setup) begin
			if (paddr == REG_CTRL) begin
				d.prdata[CTRL_ADDR +: 4] = q.addr;
			end else if (paddr == REG_STATUS) begin
				d.prdata[ST_STAGE +: 2] = q.stage;
				d.prdata[ST_STEP +: 2]  = q.step;
				d.prdata[ST_HOLD]       = q.hold;
				d.prdata[ST_MAG]        = q.mag;
				d.prdata[ST_SDIFF]      = q.sdiff;
				d.prdata[ST_OVF]        = q.ovf;
				d.prdata[ST_CP]         = complement_enable;
				d.prdata[ST_S2]         = operand_upper_select;
				d.prdata[ST_BUSY]       = busy;
				d.prdata[ST_SLOT +: 4]  = q.slot;
				d.prdata[ST_ADDR +: 4]  = q.addr;
			end else if (paddr == REG_ACC_LO) begin
				d.prdata = q.acc[31:0];
			end else if (paddr == REG_ACC_HI) begin
				d.prdata[HI_W-1:0] = q.acc[WORD_W-1:32];
			end else if (paddr == REG_OPND_LO) begin
				d.prdata = q.opnd[31:0];
			end else if (paddr == REG_OPND_HI) begin
				d.prdata[HI_W-1:0] = q.opnd[WORD_W-1:32];
			end else if (mem_hit && !paddr[2]) begin
				d.prdata = q.mem[mem_idx][31:0];
			end else if (mem_hit) begin
				d.prdata[HI_W-1:0] = q.mem[mem_idx][WORD_W-1:32];
			end else begin
				d.pslverr = 1'b1;  // Unmapped offset
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q       <= '0;
			q.addr  <= RST_ADDR;
			q.stage <= STG_ALPHA;
			q.step  <= STEP_FETCH;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign prdata        = q.prdata;
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign hold_interval = q.hold;
	assign stage_counter = q.stage;
	assign step_counter  = q.step;
	assign overflow_flag = q.ovf;
	assign control_line  = q.fline;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_end_pulse;
		(q.stage == STG_GAMMA) && (q.step == STEP_ADD) && !q.hold && (q.pulse == 6'd0);
	endsequence

	sequence s_back_to_alpha;
		(q.stage == STG_ALPHA) && (q.step == STEP_FETCH) && q.hold;
	endsequence

	a_end_returns_alpha: assert property (s_end_pulse |=> s_back_to_alpha)
		else $error("ending pulse did not return to stage 00");

	a_hold_one_cycle: assert property ($rose(q.hold) && !q.ovf |-> q.hold[*8] ##34 q.hold ##1 (!q.hold || q.ovf))
		else $error("hold interval not one minor cycle");

	a_ovf_keeps_hold: assert property (q.hold && q.ovf |=> q.hold)
		else $error("hold cleared while overflow set");

	a_cmp_then_add: assert property (comparing && (q.pulse == 6'd0) |=> (q.step == STEP_ADD) && q.hold)
		else $error("compare step did not advance on t0");

	a_flags_held: assert property (q.hold || adding |=> $stable(q.mag) && $stable(q.sdiff))
		else $error("comparison flag changed while protected");

	a_sign_differ: assert property (comparing && (q.pulse == T_SIGN) |=> q.sdiff == $past(q.acc[SIGN_BIT] ^ q.opnd[SIGN_BIT]))
		else $error("sign differ flag wrong");

	a_no_neg_zero: assert property (adding && (q.pulse == T_SIGN) && !q.nonzero |=> !q.acc[SIGN_BIT])
		else $error("negative zero written");

	a_cp_no_ovf: assert property (complement_enable && !q.ovf && !(wr && pwdata[CTRL_OVF_CLR]) |=> !q.ovf)
		else $error("overflow set during subtraction");

	a_add_lines: assert property ((q.stage == STG_GAMMA) && (q.step == STEP_ADD) |-> q.fline == FL_ADD)
		else $error("add step control lines wrong");

	a_strip_sign: assert property (adding && (bit_idx == SIGN_BIT) |-> !ad.lower)
		else $error("lower sign pulse not stripped");

	a_apb_answer: assert property (setup |=> pready ##1 !pready)
		else $error("APB answer not one cycle after setup");

endmodule : ssa_top
`default_nettype wire

// File: tb/ssa_host_model.sv
// Host side model: APB master that loads, starts and reads the add block
`timescale 1ns/1ps
`default_nettype none
module ssa_host_model (
	input  wire logic        pclk,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output var  logic        timed_out
);
	// Idle bus from time zero so the block sees no stray setup
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		timed_out = 1'b0;
	end

	// ------------------------------------------------------------
	// One transfer, request held until pready is sampled high
	// ------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Bounded wait: a slave that never answers must not hang the run
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			timed_out <= 1'b1;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : ssa_host_model
`default_nettype wire

// File: tb/ssa_top_bench.sv
// Self-checking bench for the serial signed add block
`timescale 1ns/1ps
`default_nettype none
module ssa_top_bench;
	import ssa_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hold_interval;
	logic [1:0]  stage_counter;
	logic [1:0]  step_counter;
	logic        overflow_flag;
	logic [20:0] control_line;
	logic        timed_out;
	int          errors;
	int          tests_run;
	int          hold_len;

	ssa_top ssa_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hold_interval(hold_interval), .stage_counter(stage_counter), .step_counter(step_counter),
		.overflow_flag(overflow_flag), .control_line(control_line));

	ssa_host_model ssa_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timed_out(timed_out));

	// 250 MHz clock, one bit time per period
	always #2 pclk = ~pclk;

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude;
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// A hung bus transfer ends the run as a failure
	always @(posedge pclk) begin
		if (timed_out === 1'b1) begin
			errors++;
			conclude();
		end
	end

	// Control lines checked only once the hold interval has let them settle
	always @(posedge pclk) begin
		if (presetn && stage_counter === 2'b10 && hold_interval === 1'b0)
			check(control_line, step_counter == 2'd0 ? FL_FETCH :
				step_counter == 2'd1 ? FL_COMPARE : FL_ADD);
		if (hold_interval === 1'b1)
			hold_len++;
		else if (hold_len != 0) begin
			check(hold_len, 42);
			hold_len = 0;
		end
	end

	// ------------------------------------------------------------
	// Bus helpers and expected arithmetic
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		ssa_host_model_i.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
		ssa_host_model_i.xfer(1'b0, a, 32'h0000_0000, r, e);
	endtask : rd

	// Spacer bits p0..p7 stay zero, magnitude in bits 36..8, sign in 37
	function automatic logic [41:0] mk(input logic s, input logic [28:0] m);
		return {4'h0, s, m, 8'h00};
	endfunction : mk

	function automatic void model_sum(input logic [41:0] a, input logic [41:0] b,
			output logic [41:0] e, output logic ov);
		logic [29:0] s;
		logic        sg;
		ov = 1'b0;
		if (a[37] == b[37]) begin
			s = a[36:8] + b[36:8];
			ov = s[29];
			sg = a[37];
		end else if (a[36:8] > b[36:8]) begin
			s = a[36:8] - b[36:8];
			sg = a[37];
		end else begin
			s = b[36:8] - a[36:8];
			sg = b[37];
		end
		if (s[28:0] == 29'h0)
			sg = 1'b0;
		e = {4'h0, sg, s[28:0], 8'h00};
	endfunction : model_sum

	// With idle set, also wait out the hold interval: a start during the hold after
	// the ending pulse would stretch that hold over a second minor cycle
	task automatic wait_stage(input logic [1:0] s, input logic idle);
		int n;
		n = 0;
		while ((stage_counter !== s || (idle && hold_interval !== 1'b0)) && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			errors++;
			$display("ERROR %0t: stage wait ran out", $time);
			conclude();
		end
	endtask : wait_stage

	// Load both words, start from memory word 3, then read result and flags
	task automatic run_case(input logic [41:0] a, input logic [41:0] b);
		logic [41:0] e;
		logic        ov;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] st;
		logic        er;
		model_sum(a, b, e, ov);
		wr(REG_ACC_LO, a[31:0]);
		wr(REG_ACC_HI, {22'h0, a[41:32]});
		wr(REG_MEM_BASE + 12'h018, b[31:0]);
		wr(REG_MEM_BASE + 12'h01c, {22'h0, b[41:32]});
		wait_stage(2'b00, 1'b1);
		wr(REG_CTRL, 32'h0000_0031);
		// Busy block must drop this stray load
		wr(REG_ACC_LO, 32'hffff_ff00);
		wait_stage(2'b10, 1'b0);
		wait_stage(2'b00, 1'b0);
		check(step_counter, 2'd0);
		rd(REG_ACC_LO, lo, er);
		rd(REG_ACC_HI, hi, er);
		check({hi, lo}, {22'h0, e});
		rd(REG_STATUS, st, er);
		check(st[ST_MAG], a[36:8] > b[36:8]);
		check(st[ST_SDIFF], a[37] ^ b[37]);
		check(overflow_flag, ov);
	endtask : run_case

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic        e;
		pclk = 1'b0;
		presetn = 1'b0;
		errors = 0;
		tests_run = 0;
		hold_len = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({hold_interval, stage_counter, step_counter, overflow_flag, control_line}, 64'h0);
		rd(12'h100, r, e);
		check({e, r}, {1'b1, 32'h0});
		run_case(mk(1'b0, 29'd5), mk(1'b0, 29'd3));
		run_case(mk(1'b0, 29'd10), mk(1'b1, 29'd3));
		run_case(mk(1'b1, 29'd3), mk(1'b0, 29'd10));
		run_case(mk(1'b0, 29'd5), mk(1'b1, 29'd5));
		run_case(mk(1'b1, 29'd7), mk(1'b1, 29'd2));
		run_case(mk(1'b1, 29'h1fff_ffff), mk(1'b0, 29'd1));
		run_case(mk(1'b0, 29'h1fff_ffff), mk(1'b0, 29'd1));
		// Overflow must freeze the machine in its hold interval
		repeat (200) @(posedge pclk);
		check(hold_interval, 1'b1);
		conclude();
	end
endmodule : ssa_top_bench
`default_nettype wire
